// ===== bench/cab_pins_model.sv
// Far side of port 1: count pin pulses, module lines, pull-ups.
// Assumes bits 7:3 feed modules 0 to 4 and bit 2 the count pin.
`timescale 1ns/100ps
module cab_pins_model import cab_pkg::*; (
	input  wire logic       i_clk,
	input  wire logic [7:0] i_p1_out,
	input  wire logic [7:0] i_p1_oe,
	output logic      [7:0] o_p1_pin
);
	logic       ext_r;
	logic [4:0] line_r;
	initial
	begin
		ext_r = 1'b1;
		line_r = 5'h1F;
	end
	// Driven pins read back; released bits 1:0 pulled high, released bits 7:2 take the model's count pin and line levels
	always_comb
	begin
		for (int b = 0; b < 8; b++)
			o_p1_pin[b] = i_p1_oe[b] ? i_p1_out[b] : 1'b1;
		if (!i_p1_oe[PIN_ECI])
			o_p1_pin[PIN_ECI] = ext_r;
		for (int m = 0; m < NMOD; m++)
			if (!i_p1_oe[PIN_MOD0 + m])
				o_p1_pin[PIN_MOD0 + m] = line_r[m];
	end
	// Each level held 4 clocks, so 8 clocks a cycle
	task automatic ext_pulses(input int n);
		repeat (n)
		begin
			repeat (4) @(posedge i_clk);
			ext_r <= 1'b0;
			repeat (4) @(posedge i_clk);
			ext_r <= 1'b1;
		end
	endtask
	task automatic set_line(input int m, input logic v);
		@(posedge i_clk);
		line_r[m] <= v;
	endtask
endmodule

// ===== bench/counter_array_time_base_tb.sv
// Self-checking bench for the counter array time base over APB.
// Assumes cab_top, the port 1 pin model and one 20 MHz clock.
`timescale 1ns/100ps
module counter_array_time_base_tb import cab_pkg::*;;
	logic        clk, srst, psel, penable, pwrite, tovf;
	logic [7:0]  paddr, gout, goe, pin, p1o, p1oe;
	logic [31:0] pwdata, prdata, rdata;
	logic        pready, pslverr, irq, airq, wdog, serr;
	int          n_fail, n_tests, cyc, n_wdog;

	cab_top dut (
		.i_clk(clk), .i_srst(srst), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_timer0_ovf(tovf),
		.i_p1_pin(pin), .i_gpio_out(gout), .i_gpio_oe(goe), .o_pready(pready),
		.o_prdata(prdata), .o_pslverr(pslverr), .o_irq(irq), .o_array_irq(airq),
		.o_wdog_rst(wdog), .o_p1_out(p1o), .o_p1_oe(p1oe)
	);
	cab_pins_model pins (.i_clk(clk), .i_p1_out(p1o), .i_p1_oe(p1oe), .o_p1_pin(pin));

	initial
		clk = 1'b0;
	always #25 clk = ~clk;

	// Counts watchdog reset pulses
	always @(posedge clk)
		if (wdog === 1'b1)
			n_wdog <= n_wdog + 1;

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic end_sim;
		if (n_fail == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_fail++;
			end_sim();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Hangs here are ended by the cycle ceiling
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rdata = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, rdata, exp);
	endtask
	task automatic setcnt(input logic [15:0] v);
		wr(A_CNTL, {24'h0, v[7:0]});
		wr(A_CNTH, {24'h0, v[15:8]});
	endtask
	task automatic t0(input int n);
		repeat (n)
		begin
			@(posedge clk);
			tovf <= 1'b1;
			@(posedge clk);
			tovf <= 1'b0;
		end
		repeat (4) @(posedge clk);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset;
		logic [7:0] ad [5] = '{A_MODE, A_CTRL, A_CNTL, A_CNTH, A_STAT};
		foreach (ad[i])
			rdc("reset", ad[i], 32'h0);
		apb(1'b0, 8'hFC, 32'h0);
		chk("bad_rd", rdata, 32'h0);
		chk("bad_err", 32'(serr), 32'h1);
		@(negedge clk);
		chk("gpio_out", 32'(p1o), 32'hA5);
		chk("gpio_oe", 32'(p1oe), 32'h03);
	endtask
	task automatic t_rate;
		int dv [4] = '{DIV12_SLOW, DIV12_FAST, DIV6_SLOW, DIV6_FAST};
		logic [7:0] md [4] = '{8'h00, 8'h02, 8'h80, 8'h82};
		logic [31:0] s;
		foreach (dv[i])
		begin
			setcnt(16'h0);
			wr(A_MODE, 32'(md[i]));
			wr(A_CTRL, 32'h40);
			repeat (48) @(posedge clk);
			wr(A_CTRL, 32'h0);
			apb(1'b0, A_CNTL, 32'h0);
			s = rdata;
			// Run bit stands for 51 edges: 48 waited plus 3 of the stop write
			chk("rate", s, 32'(51 / dv[i]));
			repeat (30) @(posedge clk);
			rdc("stopped", A_CNTL, s);
		end
	endtask
	task automatic t_ovf;
		wr(A_MODE, 32'h05);
		setcnt(16'hFFFE);
		wr(A_CTRL, 32'h40);
		t0(3);
		rdc("cnt_lo", A_CNTL, 32'h01);
		rdc("cnt_hi", A_CNTH, 32'h00);
		rdc("ctrl", A_CTRL, 32'hC0);
		@(negedge clk);
		chk("array_irq", 32'(airq), 32'h1);
		wr(A_IEN, 32'h01);
		repeat (2) @(negedge clk);
		chk("irq", 32'(irq), 32'h1);
		rdc("status", A_STAT, 32'h01);
		wr(A_ICLR, 32'h01);
		repeat (2) @(negedge clk);
		chk("irq_clr", 32'(irq), 32'h0);
		wr(A_MODE, 32'h04);
		repeat (2) @(negedge clk);
		chk("irq_off", 32'(airq), 32'h0);
		t0(1);
		rdc("ctrl_held", A_CTRL, 32'hC0);
		wr(A_CTRL, 32'h0);
		rdc("ctrl_clr", A_CTRL, 32'h00);
	endtask
	task automatic t_ext;
		wr(A_MODE, 32'h06);
		setcnt(16'h0);
		wr(A_CTRL, 32'h40);
		pins.ext_pulses(5);
		repeat (4) @(posedge clk);
		rdc("ext_cnt", A_CNTL, 32'h05);
		wr(A_CTRL, 32'h0);
	endtask
	task automatic t_cap;
		setcnt(16'h1234);
		wr(A_MODM, 32'h21);
		pins.set_line(0, 1'b0);
		repeat (6) @(posedge clk);
		rdc("no_cap", A_CTRL, 32'h00);
		pins.set_line(0, 1'b1);
		repeat (6) @(posedge clk);
		rdc("cap_flag", A_CTRL, 32'h01);
		rdc("cap_lo", A_CAPL, 32'h34);
		rdc("cap_hi", A_CAPH, 32'h12);
		@(negedge clk);
		chk("cap_irq", 32'(airq), 32'h1);
		wr(A_CTRL, 32'h0);
		rdc("cap_clr", A_CTRL, 32'h00);
		wr(A_MODM, 32'h10);
		pins.set_line(0, 1'b0);
		repeat (6) @(posedge clk);
		rdc("capn_flag", A_CTRL, 32'h01);
		wr(A_CTRL, 32'h0);
		wr(A_MODM, 32'h0);
	endtask
	task automatic t_cmp;
		wr(A_ICLR, 32'h3F);
		wr(A_MODE, 32'h04);
		setcnt(16'h0);
		wr(A_CAPL + 8'h04, 32'h03);
		wr(A_CAPH + 8'h04, 32'h00);
		wr(A_MODM + 8'h04, 32'h48);
		wr(A_IEN, 32'h04);
		wr(A_CTRL, 32'h40);
		t0(2);
		rdc("no_match", A_CTRL, 32'h40);
		t0(1);
		rdc("match", A_CTRL, 32'h42);
		@(negedge clk);
		chk("cmp_airq", 32'(airq), 32'h0);
		chk("cmp_irq", 32'(irq), 32'h1);
		rdc("cmp_stat", A_STAT, 32'h04);
		t0(2);
		rdc("match_held", A_CTRL, 32'h42);
	endtask
	task automatic t_wdog;
		wr(A_CTRL, 32'h0);
		setcnt(16'h0);
		wr(A_CAPL + 8'h10, 32'h01);
		wr(A_CAPH + 8'h10, 32'h00);
		wr(A_MODM + 8'h10, 32'h4C);
		wr(A_MODE, 32'h44);
		wr(A_CTRL, 32'h40);
		chk("wdog_idle", 32'(n_wdog), 32'h0);
		t0(1);
		@(negedge clk);
		chk("wdog_rst", 32'(n_wdog), 32'h1);
		chk("mod4_oe", 32'(p1oe[7]), 32'h1);
		chk("mod4_out", 32'(p1o[7]), 32'h0);
		rdc("wdog_flag", A_CTRL, 32'h50);
		wr(A_CTRL, 32'h0);
	endtask
	task automatic t_pwm;
		wr(A_CAPL + 8'h08, 32'h80);
		wr(A_MODM + 8'h08, 32'h42);
		setcnt(16'h0010);
		repeat (3) @(negedge clk);
		chk("pwm_low", 32'(p1o[5]), 32'h0);
		setcnt(16'h0090);
		repeat (3) @(negedge clk);
		chk("pwm_high", 32'(p1o[5]), 32'h1);
		chk("pwm_oe", 32'(p1oe[5]), 32'h1);
		wr(A_MODM + 8'h08, 32'h0);
	endtask

	initial
	begin
		{srst, psel, penable, pwrite, tovf} = 5'b10000;
		{paddr, pwdata, gout, goe} = {8'h00, 32'h0, 8'hA5, 8'h03};
		{n_fail, n_tests, cyc} = 0;
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		t_rate();
		t_ovf();
		t_ext();
		t_cap();
		t_cmp();
		t_wdog();
		t_pwm();
		end_sim();
	end
endmodule

// ===== rtl/cab_pkg.sv
// Constants, field positions and carrier types of the counter array time base.
// Assumes an APB slave with 8-bit byte addresses and 32-bit data.
package cab_pkg;

	// ****************************************
	// Sizes
	// ****************************************
	localparam int CNT_W = 16;
	localparam int NMOD  = 5;
	localparam int AW    = 8;

	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [AW-1:0] A_MODE = 8'h00;
	localparam logic [AW-1:0] A_CTRL = 8'h04;
	localparam logic [AW-1:0] A_CNTL = 8'h08;
	localparam logic [AW-1:0] A_CNTH = 8'h0C;
	localparam logic [AW-1:0] A_MODM = 8'h10;
	localparam logic [AW-1:0] A_CAPL = 8'h24;
	localparam logic [AW-1:0] A_CAPH = 8'h38;
	localparam logic [AW-1:0] A_STAT = 8'h4C;
	localparam logic [AW-1:0] A_ICLR = 8'h50;
	localparam logic [AW-1:0] A_IEN  = 8'h54;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int MODE_OVF_IE  = 0;
	localparam int MODE_SRC_LSB = 1;
	localparam int MODE_WDTE    = 6;
	localparam int MODE_SIX     = 7;
	localparam int CTRL_CF      = 7;
	localparam int CTRL_RUN     = 6;
	localparam int PIN_ECI      = 2;
	localparam int PIN_MOD0     = 3;
	localparam logic [7:0]       MODE_RST = 8'h00;
	localparam logic [CNT_W-1:0] CNT_RST  = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_TOP  = 16'hFFFF;

	// ****************************************
	// Count sources and prescale divisors
	// ****************************************
	localparam logic [1:0] SRC_SLOW = 2'h0;
	localparam logic [1:0] SRC_FAST = 2'h1;
	localparam logic [1:0] SRC_T0   = 2'h2;
	localparam logic [1:0] SRC_EXT  = 2'h3;
	localparam logic [3:0] DIV12_SLOW = 4'hC;
	localparam logic [3:0] DIV12_FAST = 4'h4;
	localparam logic [3:0] DIV6_SLOW  = 4'h6;
	localparam logic [3:0] DIV6_FAST  = 4'h2;

	typedef enum logic [1:0] {
		APB_IDLE = 2'b01,
		APB_ACC  = 2'b10
	} cab_apb_e;

	typedef struct packed {
		logic ecom;
		logic capp;
		logic capn;
		logic mat;
		logic tog;
		logic pwm;
		logic module_irq_enable;
	} cab_mode_s;

endpackage

// ===== rtl/cab_sync.sv
// Two-flop synchroniser for pin inputs.
// Assumes inputs are asynchronous to i_clk.
`timescale 1ns/100ps
module cab_sync #(parameter int W = 1)(
	input  wire logic         i_clk,
	input  wire logic         i_srst,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] meta_r;

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			meta_r <= '0;
			o_q    <= '0;
		end
		else
		begin
			meta_r <= i_d;
			o_q    <= meta_r;
		end
	end
endmodule

// ===== rtl/cab_top.sv
// Counter array time base: 16-bit count, source select, flags, APB slave.
// Assumes an APB master on i_clk and port 1 pins asynchronous to it.
//
// Notes on behaviour
// - one free-running 16-bit count, two bytes
// - twelve-clock sources: /12, /4, timer0, pin
// - six-clock mode: codes 00, 01 give /6, /2
// - mode bits 2:1 source, bit 0 overflow irq
// - count advances only while run bit set
// - overflow sets flag, irq if enabled
// - overflow flag cleared only by software zero
// - each module flag set on capture, or on match if module mode bit 3 set
// - module flags cleared only by software zero
// - capture, timer, output, PWM; module four watchdog
// - modules use port bits 3-7, count pin bit 2
// - unused module pins stay general purpose
// - timer0 overflow counts without its irq enabled
// - module mode bit 0 gates module flag irq
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/100ps
module cab_top import cab_pkg::*; (
	input  wire logic          i_clk,
	input  wire logic          i_srst,
	input  wire logic          i_psel,
	input  wire logic          i_penable,
	input  wire logic          i_pwrite,
	input  wire logic [AW-1:0] i_paddr,
	input  wire logic [31:0]   i_pwdata,
	input  wire logic          i_timer0_ovf,
	input  wire logic [7:0]    i_p1_pin,
	input  wire logic [7:0]    i_gpio_out,
	input  wire logic [7:0]    i_gpio_oe,
	output logic               o_pready,
	output logic      [31:0]   o_prdata,
	output logic               o_pslverr,
	output logic               o_irq,
	output logic               o_array_irq,
	output logic               o_wdog_rst,
	output logic      [7:0]    o_p1_out,
	output logic      [7:0]    o_p1_oe
);
	// ****************************************
	// Declarations
	// ****************************************
	cab_apb_e         st_r;
	logic             wr;
	logic [31:0]      rd_nxt;
	logic             err_nxt;
	logic [7:0]       mode_r;
	cab_mode_s        mmode_r [NMOD];
	logic             run_r;
	logic             cf_r;
	logic [NMOD-1:0]  ccf_r;
	logic [CNT_W-1:0] count_r;
	logic [3:0]       pre_r;
	logic [3:0]       div;
	logic             tick;
	logic             inc;
	logic             wrap;
	logic             step_r;
	logic [5:0]       pin_s;
	logic             eci_d_r;
	logic             eci_fall;
	logic             ctrl_wr;
	logic             cnt_wr;
	logic [5:0]       stat_r;
	logic [5:0]       ien_r;
	logic [NMOD-1:0]  ev;
	logic [NMOD-1:0]  uline;
	logic [NMOD-1:0]  udrive;
	logic [NMOD-1:0]  wdog_hit;
	logic [NMOD-1:0]  module_irq_enable;
	logic [NMOD-1:0]  wr_lo;
	logic [NMOD-1:0]  wr_hi;
	logic [CNT_W-1:0] ccap [NMOD];
	logic [1:0]       src;
	logic             six;

	assign src     = mode_r[MODE_SRC_LSB +: 2];
	assign six     = mode_r[MODE_SIX];
	assign wr      = (st_r == APB_ACC) & i_psel & i_penable & i_pwrite;
	assign ctrl_wr = wr & (i_paddr == A_CTRL);
	assign cnt_wr  = wr & ((i_paddr == A_CNTL) | (i_paddr == A_CNTH));

	// ****************************************
	// APB slave
	// ****************************************
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			st_r <= APB_IDLE;
		else
		begin
			case (st_r)
				APB_IDLE:
					if (i_psel & ~i_penable)
						st_r <= APB_ACC;
				APB_ACC:
					st_r <= APB_IDLE;
				default:
					st_r <= APB_IDLE;
			endcase
		end
	end

	always_comb
	begin
		rd_nxt  = 32'h0000_0000;
		err_nxt = 1'b0;
		case (i_paddr)
			A_MODE: rd_nxt[7:0] = mode_r;
			A_CTRL: rd_nxt[7:0] = {cf_r, run_r, 1'b0, ccf_r};
			A_CNTL: rd_nxt[7:0] = count_r[7:0];
			A_CNTH: rd_nxt[7:0] = count_r[15:8];
			A_STAT: rd_nxt[5:0] = stat_r;
			A_ICLR: rd_nxt      = 32'h0000_0000;
			A_IEN:  rd_nxt[5:0] = ien_r;
			default:
			begin
				err_nxt = 1'b1;
				for (int n = 0; n < NMOD; n++)
				begin
					if (i_paddr == A_MODM + AW'(4 * n))
					begin
						rd_nxt[6:0] = mmode_r[n];
						err_nxt     = 1'b0;
					end
					if (i_paddr == A_CAPL + AW'(4 * n))
					begin
						rd_nxt[7:0] = ccap[n][7:0];
						err_nxt     = 1'b0;
					end
					if (i_paddr == A_CAPH + AW'(4 * n))
					begin
						rd_nxt[7:0] = ccap[n][15:8];
						err_nxt     = 1'b0;
					end
				end
			end
		endcase
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			o_prdata  <= 32'h0000_0000;
			o_pslverr <= 1'b0;
		end
		else if ((st_r == APB_IDLE) & i_psel & ~i_penable)
		begin
			o_prdata  <= i_pwrite ? 32'h0000_0000 : rd_nxt;
			o_pslverr <= err_nxt;
		end
	end

	assign o_pready = st_r[1];

	// ****************************************
	// Mode and control registers
	// ****************************************
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			mode_r <= MODE_RST;
			run_r  <= 1'b0;
			ien_r  <= 6'h00;
			for (int n = 0; n < NMOD; n++)
				mmode_r[n] <= '0;
		end
		else
		begin
			if (wr & (i_paddr == A_MODE))
				mode_r <= i_pwdata[7:0];
			if (ctrl_wr)
				run_r <= i_pwdata[CTRL_RUN];
			if (wr & (i_paddr == A_IEN))
				ien_r <= i_pwdata[5:0];
			for (int n = 0; n < NMOD; n++)
				if (wr & (i_paddr == A_MODM + AW'(4 * n)))
					mmode_r[n] <= i_pwdata[6:0];
		end
	end

	// ****************************************
	// Count source and counter
	// ****************************************
	cab_sync #(.W(6)) u_sync (
		.i_clk  (i_clk),
		.i_srst (i_srst),
		.i_d    (i_p1_pin[7:2]),
		.o_q    (pin_s)
	);

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			eci_d_r <= 1'b0;
		else
			eci_d_r <= pin_s[0];
	end

	assign eci_fall = eci_d_r & ~pin_s[0];

	always_comb
	begin
		if (six)
			div = (src == SRC_SLOW) ? DIV6_SLOW : DIV6_FAST;
		else
			div = (src == SRC_SLOW) ? DIV12_SLOW : DIV12_FAST;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst | ~run_r)
			pre_r <= 4'h0;
		else if (pre_r >= div - 4'h1)
			pre_r <= 4'h0;
		else
			pre_r <= pre_r + 4'h1;
	end

	always_comb
	begin
		case (src)
			SRC_T0:  tick = i_timer0_ovf;
			SRC_EXT: tick = eci_fall;
			default: tick = (pre_r >= div - 4'h1);
		endcase
	end

	assign inc  = run_r & tick;
	assign wrap = inc & (count_r == CNT_TOP);

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			count_r <= CNT_RST;
			step_r  <= 1'b0;
		end
		else
		begin
			step_r <= inc;
			if (wr & (i_paddr == A_CNTL))
				count_r[7:0] <= i_pwdata[7:0];
			else if (wr & (i_paddr == A_CNTH))
				count_r[15:8] <= i_pwdata[7:0];
			else if (inc)
				count_r <= count_r + 16'h0001;
		end
	end

	// ****************************************
	// Compare/capture modules
	// ****************************************
	for (genvar g = 0; g < NMOD; g++)
	begin : g_mod
		assign wr_lo[g] = wr & (i_paddr == A_CAPL + AW'(4 * g));
		assign wr_hi[g] = wr & (i_paddr == A_CAPH + AW'(4 * g));
		assign module_irq_enable[g]  = mmode_r[g].module_irq_enable;
		cab_unit #(.WDOG_OK(g == NMOD - 1)) u_unit (
			.i_clk      (i_clk),
			.i_srst     (i_srst),
			.i_mode     (mmode_r[g]),
			.i_count    (count_r),
			.i_step     (step_r),
			.i_line     (pin_s[g + 1]),
			.i_wr_lo    (wr_lo[g]),
			.i_wr_hi    (wr_hi[g]),
			.i_wdata    (i_pwdata[7:0]),
			.i_wdog_en  (mode_r[MODE_WDTE]),
			.o_event    (ev[g]),
			.o_line     (uline[g]),
			.o_drive    (udrive[g]),
			.o_ccap     (ccap[g]),
			.o_wdog_hit (wdog_hit[g])
		);
	end

	// ****************************************
	// Flags and interrupts
	// ****************************************
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			cf_r  <= 1'b0;
			ccf_r <= '0;
		end
		else
		begin
			cf_r  <= wrap | (cf_r & ~(ctrl_wr & ~i_pwdata[CTRL_CF]));
			ccf_r <= ev | (ccf_r & ~({NMOD{ctrl_wr}} & ~i_pwdata[NMOD-1:0]));
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			stat_r <= 6'h00;
		else if (wr & (i_paddr == A_ICLR))
			stat_r <= {ev, wrap} | (stat_r & ~i_pwdata[5:0]);
		else
			stat_r <= {ev, wrap} | stat_r;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			o_irq       <= 1'b0;
			o_array_irq <= 1'b0;
			o_wdog_rst  <= 1'b0;
		end
		else
		begin
			o_irq       <= |(stat_r & ien_r);
			o_array_irq <= (cf_r & mode_r[MODE_OVF_IE]) | (|(ccf_r & module_irq_enable));
			o_wdog_rst  <= |wdog_hit;
		end
	end

	// ****************************************
	// Port 1 pin sharing
	// ****************************************
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			o_p1_out <= 8'hFF;
			o_p1_oe  <= 8'h00;
		end
		else
		begin
			o_p1_out <= i_gpio_out;
			o_p1_oe  <= i_gpio_oe;
			for (int n = 0; n < NMOD; n++)
				if (udrive[n])
				begin
					o_p1_out[PIN_MOD0 + n] <= uline[n];
					o_p1_oe[PIN_MOD0 + n]  <= 1'b1;
				end
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	sequence s_setup;
		(st_r == APB_IDLE) & i_psel & ~i_penable;
	endsequence

	sequence s_answer;
		o_pready ##1 ~o_pready;
	endsequence

	property p_apb_answer;
		@(posedge i_clk) disable iff (i_srst) s_setup |=> s_answer;
	endproperty
	a_apb_answer: assert property (p_apb_answer) else $error("pready not one cycle after setup");

	property p_wrap_flag;
		@(posedge i_clk) disable iff (i_srst) wrap |=> cf_r && count_r == CNT_RST;
	endproperty
	a_wrap_flag: assert property (p_wrap_flag) else $error("wrap did not set flag");

	property p_cf_sticky;
		@(posedge i_clk) disable iff (i_srst)
			cf_r & ~(ctrl_wr & ~i_pwdata[CTRL_CF]) |=> cf_r;
	endproperty
	a_cf_sticky: assert property (p_cf_sticky) else $error("overflow flag lost");

	property p_stopped;
		@(posedge i_clk) disable iff (i_srst) ~run_r & ~cnt_wr |=> $stable(count_r);
	endproperty
	a_stopped: assert property (p_stopped) else $error("count moved while stopped");

	property p_ccf_set;
		@(posedge i_clk) disable iff (i_srst) ev[0] |=> ccf_r[0];
	endproperty
	a_ccf_set: assert property (p_ccf_set) else $error("module event not flagged");

	property p_ccf_sticky;
		@(posedge i_clk) disable iff (i_srst) ccf_r[4] & ~ctrl_wr |=> ccf_r[4];
	endproperty
	a_ccf_sticky: assert property (p_ccf_sticky) else $error("module flag lost");

	property p_slow12;
		@(posedge i_clk) disable iff (i_srst)
			inc & run_r & ~six & (src == SRC_SLOW) & ~wr ##1 run_r & ~wr |-> ~inc [*8];
	endproperty
	a_slow12: assert property (p_slow12) else $error("slow count too fast");

	property p_fast6;
		@(posedge i_clk) disable iff (i_srst)
			inc & six & (src == SRC_FAST) & ~wr ##1 ~wr |-> ~inc ##1 inc;
	endproperty
	a_fast6: assert property (p_fast6) else $error("six-clock fast rate wrong");

	property p_timer0;
		@(posedge i_clk) disable iff (i_srst)
			run_r & (src == SRC_T0) & i_timer0_ovf & ~cnt_wr
			|=> count_r == $past(count_r) + 16'h0001;
	endproperty
	a_timer0: assert property (p_timer0) else $error("timer0 overflow not counted");

	property p_ext_fall;
		@(posedge i_clk) disable iff (i_srst)
			run_r & (src == SRC_EXT) & ~cnt_wr & eci_d_r & ~pin_s[0]
			|=> count_r == $past(count_r) + 16'h0001;
	endproperty
	a_ext_fall: assert property (p_ext_fall) else $error("pin fall not counted");

	property p_irq_gate;
		@(posedge i_clk) disable iff (i_srst)
			|(ccf_r & module_irq_enable) |=> o_array_irq;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("module irq missing");
endmodule

// ===== rtl/cab_unit.sv
// One compare/capture module fed by the common count.
// Assumes i_line is already synchronised and i_step marks a fresh count.
`timescale 1ns/100ps
module cab_unit import cab_pkg::*; #(parameter bit WDOG_OK = 1'b0)(
	input  wire logic             i_clk,
	input  wire logic             i_srst,
	input  wire cab_mode_s        i_mode,
	input  wire logic [CNT_W-1:0] i_count,
	input  wire logic             i_step,
	input  wire logic             i_line,
	input  wire logic             i_wr_lo,
	input  wire logic             i_wr_hi,
	input  wire logic [7:0]       i_wdata,
	input  wire logic             i_wdog_en,
	output logic                  o_event,
	output logic                  o_line,
	output logic                  o_drive,
	output logic      [CNT_W-1:0] o_ccap,
	output logic                  o_wdog_hit
);
	logic line_d_r;
	logic match;
	logic capt;

	assign match = i_mode.ecom & i_step & (i_count == o_ccap);
	assign capt  = ~i_mode.ecom & ((i_mode.capp & i_line & ~line_d_r)
		| (i_mode.capn & ~i_line & line_d_r));

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			line_d_r <= 1'b0;
		else
			line_d_r <= i_line;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			o_ccap <= CNT_RST;
		else if (i_wr_lo)
			o_ccap[7:0] <= i_wdata;
		else if (i_wr_hi)
			o_ccap[15:8] <= i_wdata;
		else if (capt)
			o_ccap <= i_count;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			o_event    <= 1'b0;
			o_line     <= 1'b1;
			o_drive    <= 1'b0;
			o_wdog_hit <= 1'b0;
		end
		else
		begin
			o_event    <= capt | (match & i_mode.mat);
			o_drive    <= i_mode.ecom & (i_mode.tog | i_mode.pwm);
			o_wdog_hit <= WDOG_OK & i_wdog_en & match & i_mode.mat;
			if (i_mode.pwm)
				o_line <= (i_count[7:0] >= o_ccap[7:0]);
			else if (i_mode.tog & match)
				o_line <= ~o_line;
		end
	end
endmodule
